// ### common/sdcke_pkg.sv
// shared constants and types for the clock-enable / data-mask link
package sdcke_pkg;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int BURST_LEN = 4;
	localparam int BANKS = 4;
	localparam logic [2:0] BURST_LEN_M1 = 3'h3;
	localparam int READ_MASK_LAT = 2;
	localparam int CLK_PERIOD_NS = 100;
	localparam int REFRESH_PERIOD_MS = 64;
	localparam int REFRESH_CYCLES = REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int EXIT_GAP_CYCLES = 1;
	localparam logic [1:0] CMD_NOP = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_READ = 2'h2;
	localparam logic [1:0] CMD_DESELECT = 2'h3;
	typedef enum logic [1:0] {
		SDCKE_IDLE = 2'b00,
		SDCKE_WRITE = 2'b01,
		SDCKE_READ = 2'b10
	} sdcke_op_t;
	typedef enum logic [1:0] {
		SDCKE_RUN = 2'b00,
		SDCKE_SUSPEND = 2'b01,
		SDCKE_PDOWN = 2'b10
	} sdcke_pwr_t;
endpackage : sdcke_pkg

// ### common/sdcke_if.sv
// command-pin interface between controller and memory
`timescale 1ns/10ps
`default_nettype none
interface sdcke_if;
	logic clock_enable_in;
	logic [1:0] cmd;
	logic [1:0] bank;
	logic data_mask_in;
	logic [sdcke_pkg::DATA_W-1:0] dq_ctl_o;
	logic dq_ctl_oe;
	logic [sdcke_pkg::DATA_W-1:0] dq_mem_o;
	logic dq_mem_oe;
	wire [sdcke_pkg::DATA_W-1:0] dq = dq_ctl_oe ? dq_ctl_o : (dq_mem_oe ? dq_mem_o : '0);
	modport ctl (output clock_enable_in, output cmd, output bank, output data_mask_in,
		output dq_ctl_o, output dq_ctl_oe, input dq_mem_o, input dq_mem_oe);
	modport mem (input clock_enable_in, input cmd, input bank, input data_mask_in,
		input dq_ctl_o, input dq_ctl_oe, output dq_mem_o, output dq_mem_oe);
endinterface : sdcke_if
`default_nettype wire

// ### rtl/sdcke_fifo.sv
// parameterised valid/ready fifo in flip-flops
`timescale 1ns/10ps
`default_nettype none
module sdcke_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
	assign out_valid_o = cnt_r != '0;
	assign out_data_o = mem_r[rp_r];
	always_comb begin
		wp_nxt = push ? wp_r + AW'(1) : wp_r;
		rp_nxt = pop ? rp_r + AW'(1) : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end
endmodule : sdcke_fifo
`default_nettype wire

// ### rtl/sdcke_mem.sv
// memory end: clock suspend, power-down and data-mask behaviour
// Overview of operation
// R1 - cke low in burst masks clock next cycle
// R2 - suspended: burst position and data frozen
// R3 - cke low with banks idle enters power-down
// R4 - power-down disables buffers except clock enable
// R5 - controller keeps suspend shorter than refresh period
// R6 - cke high restarts clock next cycle, resumes
// R7 - controller sends nop or deselect on exit
// R8 - power-down exit re-enables all buffers
// R9 - controller meets power-down exit setup time
// R10 - controller waits one cycle after exit
// R11 - write mask high leaves word unwritten
// R12 - read mask low drives, high floats outputs
// R13 - exit setup is setup plus one period
// R14 - write mask same cycle, read mask two later
`timescale 1ns/10ps
`default_nettype none
module sdcke_mem #(
	parameter int DATA_W = sdcke_pkg::DATA_W,
	parameter int WORDS = 64
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	sdcke_if.mem bus,
	output logic powered_down_o,
	output logic suspended_o,
	output logic [7:0] masked_writes_o
);
	localparam int AW = $clog2(WORDS);
	logic [DATA_W-1:0] store_r [WORDS];
	sdcke_pkg::sdcke_op_t op_r, op_nxt;
	sdcke_pkg::sdcke_pwr_t pwr_r, pwr_nxt;
	logic [2:0] beat_r, beat_nxt;
	logic [AW-1:0] addr_r, addr_nxt;
	logic [sdcke_pkg::READ_MASK_LAT-1:0] rmask_r, rmask_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [7:0] mcnt_r, mcnt_nxt;
	logic live, wr_en, inbuf_on;
	// clock enable is sampled: internal clock runs this cycle only if it was high last edge
	assign inbuf_on = pwr_r != sdcke_pkg::SDCKE_PDOWN; // R4 R8
	assign live = pwr_r == sdcke_pkg::SDCKE_RUN; // R1 R6
	assign wr_en = live && op_r == sdcke_pkg::SDCKE_WRITE && inbuf_on
		&& !bus.data_mask_in; // R11 R14
	always_comb begin
		op_nxt = op_r;
		beat_nxt = beat_r;
		addr_nxt = addr_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = rvalid_r;
		rmask_nxt = rmask_r;
		mcnt_nxt = mcnt_r;
		pwr_nxt = pwr_r;
		if (live) begin
			// R2 everything below only advances on a live internal clock
			rmask_nxt = {rmask_r[sdcke_pkg::READ_MASK_LAT-2:0], bus.data_mask_in}; // R14
			if (op_r != sdcke_pkg::SDCKE_IDLE) begin
				addr_nxt = addr_r + AW'(1);
				beat_nxt = beat_r + 3'h1;
				if (op_r == sdcke_pkg::SDCKE_WRITE && bus.data_mask_in && mcnt_r != 8'hff) begin
					mcnt_nxt = mcnt_r + 8'h01; // R11
				end
				if (beat_r == sdcke_pkg::BURST_LEN_M1) begin
					op_nxt = sdcke_pkg::SDCKE_IDLE;
				end
			end
			rvalid_nxt = op_r == sdcke_pkg::SDCKE_READ;
			rdata_nxt = store_r[addr_r];
			if (op_nxt == sdcke_pkg::SDCKE_IDLE) begin
				// new commands; nop and deselect do nothing (R7)
				if (bus.cmd == sdcke_pkg::CMD_WRITE) begin
					op_nxt = sdcke_pkg::SDCKE_WRITE;
				end else if (bus.cmd == sdcke_pkg::CMD_READ) begin
					op_nxt = sdcke_pkg::SDCKE_READ;
				end
				if (bus.cmd == sdcke_pkg::CMD_WRITE || bus.cmd == sdcke_pkg::CMD_READ) begin
					beat_nxt = '0;
					addr_nxt = AW'({bus.bank, 4'h0});
				end
			end
		end
		if (!bus.clock_enable_in) begin
			if (pwr_r == sdcke_pkg::SDCKE_RUN) begin
				// idle banks mean power-down, a running burst means suspend
				pwr_nxt = (op_r == sdcke_pkg::SDCKE_IDLE && !rvalid_r)
					? sdcke_pkg::SDCKE_PDOWN : sdcke_pkg::SDCKE_SUSPEND; // R1 R3
			end
		end else begin
			pwr_nxt = sdcke_pkg::SDCKE_RUN; // R6 R8
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_r <= sdcke_pkg::SDCKE_IDLE;
			pwr_r <= sdcke_pkg::SDCKE_RUN;
			beat_r <= '0;
			addr_r <= '0;
			rmask_r <= '1;
			rdata_r <= '0;
			rvalid_r <= 1'b0;
			mcnt_r <= '0;
			powered_down_o <= 1'b0;
			suspended_o <= 1'b0;
			masked_writes_o <= '0;
			bus.dq_mem_oe <= 1'b0;
			bus.dq_mem_o <= '0;
		end else begin
			op_r <= op_nxt;
			pwr_r <= pwr_nxt;
			beat_r <= beat_nxt;
			addr_r <= addr_nxt;
			rmask_r <= rmask_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			mcnt_r <= mcnt_nxt;
			powered_down_o <= pwr_nxt == sdcke_pkg::SDCKE_PDOWN;
			suspended_o <= pwr_nxt == sdcke_pkg::SDCKE_SUSPEND;
			masked_writes_o <= mcnt_nxt;
			// output drivers off in power-down and while masked two cycles back
			bus.dq_mem_oe <= rvalid_nxt && !rmask_nxt[sdcke_pkg::READ_MASK_LAT-1]
				&& pwr_nxt != sdcke_pkg::SDCKE_PDOWN; // R4 R12 R14
			bus.dq_mem_o <= rdata_nxt;
		end
	end
	always_ff @(posedge clk_i) begin
		if (wr_en) begin
			store_r[addr_r] <= bus.dq_ctl_o; // R11
		end
	end
endmodule : sdcke_mem
`default_nettype wire

// ### rtl/sdcke_ctl.sv
// controller end: issues bursts, drives clock enable and mask, buffers read data
`timescale 1ns/10ps
`default_nettype none
module sdcke_ctl #(
	parameter int DATA_W = sdcke_pkg::DATA_W,
	parameter int DEPTH = sdcke_pkg::FIFO_DEPTH,
	parameter int MAX_LOW = sdcke_pkg::REFRESH_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	sdcke_if.ctl bus,
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic [1:0] req_bank_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wmask_i,
	input wire logic sleep_i,
	output logic busy_o,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [DATA_W-1:0] rd_data_o
);
	logic cke_r, cke_nxt, gap_r, gap_nxt;
	logic [1:0] cmd_r, cmd_nxt;
	logic [31:0] low_r, low_nxt;
	logic [2:0] left_r, left_nxt;
	logic fifo_ready, fifo_valid;
	logic [DATA_W-1:0] fifo_data;
	// suspend while the read fifo is full: back-pressure reaches the memory
	always_comb begin
		cmd_nxt = sdcke_pkg::CMD_NOP;
		gap_nxt = 1'b0;
		left_nxt = left_r;
		low_nxt = cke_r ? '0 : low_r + 32'h1;
		cke_nxt = !(sleep_i || !fifo_ready) || low_r >= 32'(MAX_LOW - 2); // R5
		if (!cke_r && cke_nxt) begin
			gap_nxt = 1'b1; // R10 R13
		end
		if (cke_r && cke_nxt && !gap_r) begin
			if (left_r != '0) begin
				left_nxt = left_r - 3'h1;
			end else if (req_i) begin
				cmd_nxt = req_write_i ? sdcke_pkg::CMD_WRITE : sdcke_pkg::CMD_READ;
				left_nxt = sdcke_pkg::BURST_LEN_M1;
			end
		end
		if (!cke_r) begin
			cmd_nxt = sdcke_pkg::CMD_DESELECT; // R7 R9
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cke_r <= 1'b1;
			gap_r <= 1'b0;
			cmd_r <= sdcke_pkg::CMD_NOP;
			low_r <= '0;
			left_r <= '0;
			busy_o <= 1'b0;
		end else begin
			cke_r <= cke_nxt;
			gap_r <= gap_nxt;
			cmd_r <= cmd_nxt;
			low_r <= low_nxt;
			left_r <= left_nxt;
			busy_o <= left_nxt != '0 || !cke_nxt || gap_nxt;
		end
	end
	always_comb begin
		bus.clock_enable_in = cke_r;
		bus.cmd = cmd_r;
		bus.bank = req_bank_i;
		bus.data_mask_in = wmask_i;
		bus.dq_ctl_o = wdata_i;
		bus.dq_ctl_oe = req_write_i;
	end
	sdcke_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(bus.dq_mem_oe),
		.in_ready_o(fifo_ready),
		.in_data_i(bus.dq_mem_o),
		.out_valid_o(fifo_valid),
		.out_ready_i(rd_ready_i),
		.out_data_o(fifo_data)
	);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o <= '0;
		end else begin
			rd_valid_o <= fifo_valid;
			rd_data_o <= fifo_data;
		end
	end
endmodule : sdcke_ctl
`default_nettype wire

// ### tb/sdcke_monitor.sv
// link checker: clock enable, suspend, power-down and data mask
`timescale 1ns/10ps
`default_nettype none
module sdcke_monitor #(
	parameter int MAX_LOW = 50
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clock_enable_in,
	input wire logic [1:0] cmd,
	input wire logic data_mask_in,
	input wire logic dq_mem_oe,
	input wire logic [sdcke_pkg::DATA_W-1:0] dq_mem_o,
	input wire logic powered_down_o,
	input wire logic suspended_o
);
	logic [31:0] low_r;
	logic [31:0] low_nxt;
	logic asleep;
	logic quiet_cmd;
	assign asleep = suspended_o || powered_down_o;
	assign quiet_cmd = cmd == sdcke_pkg::CMD_NOP || cmd == sdcke_pkg::CMD_DESELECT;
	always_comb begin
		low_nxt = clock_enable_in ? 32'h0 : low_r + 32'h1;
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_r <= 32'h0;
		end else begin
			low_r <= low_nxt;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_SUSP_ENTRY: assert property (!clock_enable_in && dq_mem_oe |-> ##[1:2] asleep)
		else $error("no suspend in burst");
	AST_FROZEN: assert property (suspended_o && !clock_enable_in |=> $stable(dq_mem_oe))
		else $error("output moved while suspended");
	AST_PD_EXCL: assert property (powered_down_o |-> !suspended_o)
		else $error("suspend and power-down together");
	AST_PD_QUIET: assert property (powered_down_o |-> !dq_mem_oe)
		else $error("driving in power-down");
	AST_LOW_LIMIT: assert property (low_r <= MAX_LOW)
		else $error("clock enable low too long");
	AST_WAKE: assert property (asleep && clock_enable_in |=> !asleep)
		else $error("no wake after clock enable high");
	AST_EXIT_NOP: assert property ($rose(clock_enable_in) |-> quiet_cmd)
		else $error("command on exit cycle");
	AST_EXIT_GAP: assert property ($rose(clock_enable_in) |=> quiet_cmd)
		else $error("command in gap cycle");
	AST_RD_MASK: assert property (dq_mem_oe && $past(clock_enable_in, 2) |-> !$past(data_mask_in, 2))
		else $error("driving with mask high");
	cover property (suspended_o);
	cover property (powered_down_o);
	cover property ($rose(clock_enable_in));
endmodule : sdcke_monitor
`default_nettype wire

// ### tb/tb_top.sv
// bench: controller and memory joined, accesses, sleep and readback
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int LOW = 50;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic req_i = 1'b0;
	logic req_write_i = 1'b0;
	logic [1:0] req_bank_i = 2'h0;
	logic [15:0] wdata_i = 16'h0;
	logic wmask_i = 1'b0;
	logic sleep_i = 1'b0;
	logic rd_ready_i = 1'b1;
	logic busy_o, rd_valid_o, powered_down_o, suspended_o;
	logic [15:0] rd_data_o;
	logic [7:0] masked_writes_o;
	logic [15:0] got[$];
	logic [15:0] exp_w[4] = '{16'h1234, 16'h5a5a, 16'h0f0f, 16'h1234};
	logic saw_susp = 1'b0;
	logic rdy_d = 1'b0;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	sdcke_if link ();
	sdcke_ctl #(.MAX_LOW(LOW)) sdcke_ctl_i (.clk_i, .rst_n_i, .bus(link), .req_i, .req_write_i,
		.req_bank_i, .wdata_i, .wmask_i, .sleep_i, .busy_o, .rd_valid_o, .rd_ready_i, .rd_data_o);
	sdcke_mem sdcke_mem_i (.clk_i, .rst_n_i, .bus(link), .powered_down_o, .suspended_o,
		.masked_writes_o);
	sdcke_monitor #(.MAX_LOW(LOW)) sdcke_monitor_i (.clk_i, .rst_n_i,
		.clock_enable_in(link.clock_enable_in), .cmd(link.cmd), .data_mask_in(link.data_mask_in),
		.dq_mem_oe(link.dq_mem_oe), .dq_mem_o(link.dq_mem_o), .powered_down_o, .suspended_o);
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	// wdata and mask pass straight to the link, so they are held until the next access
	task automatic access(input logic wr, input logic [1:0] bk, input logic [15:0] d, input logic m);
		int t;
		t = 0;
		@(posedge clk_i);
		req_write_i <= wr;
		req_bank_i <= bk;
		wdata_i <= d;
		wmask_i <= m;
		req_i <= 1'b1;
		do begin
			@(negedge clk_i);
			t++;
		end while (busy_o !== 1'b1 && t < 40);
		@(posedge clk_i);
		req_i <= 1'b0;
		while (busy_o !== 1'b0 && t < 200) begin
			@(negedge clk_i);
			t++;
		end
		// memory beats trail the controller's busy flag by two cycles
		repeat (4) @(negedge clk_i);
	endtask : access
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (suspended_o === 1'b1) begin
			saw_susp <= 1'b1;
		end
		rdy_d <= rd_ready_i;
		// the output register holds the word popped on the previous edge
		if (rd_valid_o === 1'b1 && rdy_d === 1'b1) begin
			got.push_back(rd_data_o);
		end
		if (cyc == 4000) begin
			n_fail++;
			give_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		access(1'b1, 2'h0, 16'h1234, 1'b0);
		access(1'b1, 2'h1, 16'h5a5a, 1'b0);
		access(1'b1, 2'h1, 16'hffff, 1'b1);
		check("masked", {8'h0, masked_writes_o}, 16'h0004);
		fork
			access(1'b1, 2'h2, 16'h0f0f, 1'b0);
			begin
				@(negedge clk_i iff busy_o === 1'b1);
				@(posedge clk_i);
				sleep_i <= 1'b1;
				repeat (3) @(posedge clk_i);
				sleep_i <= 1'b0;
			end
		join
		check("suspend", {15'h0, saw_susp}, 16'h0001);
		@(posedge clk_i);
		sleep_i <= 1'b1;
		repeat (10) @(negedge clk_i);
		check("pdown", {15'h0, powered_down_o}, 16'h0001);
		@(posedge clk_i);
		sleep_i <= 1'b0;
		repeat (4) @(negedge clk_i);
		check("wake", {15'h0, powered_down_o}, 16'h0000);
		@(posedge clk_i);
		rd_ready_i <= 1'b0;
		for (int b = 0; b < 4; b++) begin
			access(1'b0, b == 3 ? 2'h0 : 2'(b), 16'h0, 1'b0);
		end
		@(posedge clk_i);
		rd_ready_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		check("words", 16'(got.size()), 16'h0010);
		foreach (got[i]) check("rdata", got[i], exp_w[i / 4]);
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
